// *** common/supervisor_pkg.sv ***
// Purpose: Shared constants and types for the supply supervisor watchdog.
// Assumes: 250 MHz core clock; all durations counted on a 1 us timebase.
// Notes:   Times are kept in their own unit; counts are derived from them.

package supervisor_pkg;

  // ---------------------------------------------------------------
  // Clock and timebase
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS = 1000;
  // Least time, so round up to whole clock cycles.
  localparam int unsigned TICK_CYCLES =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int unsigned PRESC_W = 8;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);

  // ---------------------------------------------------------------
  // Durations in milliseconds
  // ---------------------------------------------------------------
  localparam int unsigned RESET_ACTIVE_MS = 610;
  localparam int unsigned WD_LOW_MS = 150;
  localparam int unsigned WD_FLOAT_MS = 600;
  localparam int unsigned WD_HIGH_MS = 1200;
  localparam int unsigned DEBOUNCE_MS = 4;

  // ---------------------------------------------------------------
  // Terminal counts in timebase ticks
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W = 22;
  localparam logic [CNT_W-1:0] RESET_TICKS_DEF =
    CNT_W'(RESET_ACTIVE_MS * TICKS_PER_MS);
  localparam logic [CNT_W-1:0] WD_LOW_TICKS_DEF =
    CNT_W'(WD_LOW_MS * TICKS_PER_MS);
  localparam logic [CNT_W-1:0] WD_FLOAT_TICKS_DEF =
    CNT_W'(WD_FLOAT_MS * TICKS_PER_MS);
  localparam logic [CNT_W-1:0] WD_HIGH_TICKS_DEF =
    CNT_W'(WD_HIGH_MS * TICKS_PER_MS);
  localparam logic [CNT_W-1:0] DEBOUNCE_TICKS_DEF =
    CNT_W'(DEBOUNCE_MS * TICKS_PER_MS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 22'h000001;

  // ---------------------------------------------------------------
  // Pin encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] TSEL_LOW = 2'h0;
  localparam logic [1:0] TSEL_FLOAT = 2'h1;
  localparam logic [1:0] TSEL_HIGH = 2'h2;
  localparam logic THR_5PCT = 1'h0;
  localparam logic THR_10PCT = 1'h1;

  // ---------------------------------------------------------------
  // Reset sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    st_hold = 2'b00,
    st_pulse = 2'b01,
    st_run = 2'b10
  } sup_state_e;

endpackage

// *** src/manual_reset_debounce.sv ***
// Purpose: Debounce filter for the active-low manual reset input.
// Assumes: Input is synchronous to ref_clk_in; tick is a one-cycle pulse.
// Notes:   The filtered level only flips after a full stable interval.

`timescale 1ns/10ps
`default_nettype none

module manual_reset_debounce #(
  parameter logic [supervisor_pkg::CNT_W-1:0] DEBOUNCE_TICKS =
    supervisor_pkg::DEBOUNCE_TICKS_DEF
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Timebase and raw input.
  input wire logic tick_in,
  input wire logic manual_reset_n_in,
  // Filtered press level, high while the button is held.
  output logic pressed_out
);

  logic raw_ff;
  logic nxt_raw;
  logic stable_ff;
  logic nxt_stable;
  logic [supervisor_pkg::CNT_W-1:0] cnt_ff;
  logic [supervisor_pkg::CNT_W-1:0] nxt_cnt;

  // ---------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------

  // Any disagreement shorter than the interval restarts the count, so
  // a glitch never reaches the reset logic.
  always_comb begin
    nxt_raw = manual_reset_n_in;
    nxt_stable = stable_ff;
    nxt_cnt = cnt_ff;
    if (raw_ff == stable_ff) begin
      nxt_cnt = supervisor_pkg::CNT_ZERO; // [R9]
    end else if (tick_in) begin
      if (cnt_ff == DEBOUNCE_TICKS - supervisor_pkg::CNT_ONE) begin
        nxt_stable = raw_ff; // [R7]
        nxt_cnt = supervisor_pkg::CNT_ZERO;
      end else begin
        nxt_cnt = cnt_ff + supervisor_pkg::CNT_ONE; // [R16]
      end
    end
  end

  // Released is the safe starting level.
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      raw_ff <= 1'b1;
      stable_ff <= 1'b1;
      cnt_ff <= supervisor_pkg::CNT_ZERO;
    end else begin
      raw_ff <= nxt_raw;
      stable_ff <= nxt_stable;
      cnt_ff <= nxt_cnt;
    end
  end

  assign pressed_out = ~stable_ff;

endmodule // manual_reset_debounce

`default_nettype wire

// *** src/supply_supervisor_watchdog.sv ***
// Purpose: Supply supervisor with manual reset and watchdog, driving a
//          complementary reset pair toward a host processor.
// Assumes: Supply comparator is abstracted as supply_good_in; all other
//          inputs are synchronous to ref_clk_in.
// Notes:   Durations are counted on a free-running 1 us timebase.
//
// Behaviour
// [R1] Hold reset at least 250 ms after supply becomes good, power-up included.
// [R2] Active-high reset plus open-drain active-low reset, always its inverse.
// [R3] Reset on supply low, manual press, missed strobe or power-up.
// [R4] Assert both resets within 50 us of detecting low supply.
// [R5] Each reset pulse lasts 250 ms to 1000 ms, 610 ms typical.
// [R6] Threshold select picks 5 percent when low, 10 percent when high.
// [R7] Manual reset held low over 20 ms is always recognised as reset.
// [R8] Keep reset at least 250 ms after manual reset is released.
// [R9] Manual reset input is debounced so glitches cause no reset.
// [R10] Timeout select: low 150 ms, floating 600 ms, high 1200 ms.
// [R11] Watchdog runs only while reset outputs are inactive.
// [R12] Missing strobe falling edge within timeout gives a reset pulse.
// [R13] Each strobe falling edge in time restarts the watchdog from zero.
// [R14] Strobe pulses down to 20 ns are detected at full clock rate.
// [R15] Host must strobe at least once every timeout period.
// [R16] All durations count a free-running timebase with parameter limits.
// [R17] Supply-good input is synchronised; low means below threshold.

`timescale 1ns/10ps
`default_nettype none

module supply_supervisor_watchdog #(
  parameter logic [supervisor_pkg::CNT_W-1:0] RESET_TICKS =
    supervisor_pkg::RESET_TICKS_DEF,
  parameter logic [supervisor_pkg::CNT_W-1:0] WD_LOW_TICKS =
    supervisor_pkg::WD_LOW_TICKS_DEF,
  parameter logic [supervisor_pkg::CNT_W-1:0] WD_FLOAT_TICKS =
    supervisor_pkg::WD_FLOAT_TICKS_DEF,
  parameter logic [supervisor_pkg::CNT_W-1:0] WD_HIGH_TICKS =
    supervisor_pkg::WD_HIGH_TICKS_DEF,
  parameter logic [supervisor_pkg::CNT_W-1:0] DEBOUNCE_TICKS =
    supervisor_pkg::DEBOUNCE_TICKS_DEF
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Monitored conditions.
  input wire logic supply_good_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_strobe_in,
  // Configuration pins.
  input wire logic [1:0] timeout_select_in,
  input wire logic threshold_select_in,
  // Threshold choice toward the comparator.
  output logic threshold_level_out,
  // Reset pair; the active-low one is open drain.
  output logic reset_out,
  output logic reset_n_out,
  output logic reset_n_oe_out
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [supervisor_pkg::PRESC_W-1:0] presc_ff;
  logic [supervisor_pkg::PRESC_W-1:0] nxt_presc;
  logic tick;
  logic supply_meta_ff;
  logic supply_sync_ff;
  logic strobe_prev_ff;
  logic nxt_strobe_prev;
  logic strobe_fall;
  logic mr_pressed;
  logic cause;
  logic [supervisor_pkg::CNT_W-1:0] wd_limit_ff;
  logic [supervisor_pkg::CNT_W-1:0] nxt_wd_limit;
  logic threshold_ff;
  logic nxt_threshold;
  supervisor_pkg::sup_state_e state_ff;
  supervisor_pkg::sup_state_e nxt_state;
  logic [supervisor_pkg::CNT_W-1:0] pulse_cnt_ff;
  logic [supervisor_pkg::CNT_W-1:0] nxt_pulse_cnt;
  logic [supervisor_pkg::CNT_W-1:0] wd_cnt_ff;
  logic [supervisor_pkg::CNT_W-1:0] nxt_wd_cnt;
  logic reset_ff;
  logic nxt_reset;

  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------

  // A prescaler keeps the long counters narrow; the price is up to one
  // microsecond of jitter on each duration, far inside the limits.
  always_comb begin
    if (presc_ff == supervisor_pkg::PRESC_LAST) begin
      nxt_presc = '0;
    end else begin
      nxt_presc = presc_ff + 8'h01; // [R16]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= nxt_presc;
    end
  end

  assign tick = (presc_ff == supervisor_pkg::PRESC_LAST);

  // ---------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------

  // Two-stage synchroniser; only the second stage is ever looked at.
  // It starts low so power-up looks like a supply that is not yet good.
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      supply_meta_ff <= 1'b0;
      supply_sync_ff <= 1'b0;
    end else begin
      supply_meta_ff <= supply_good_in; // [R17]
      supply_sync_ff <= supply_meta_ff;
    end
  end

  // The strobe is sampled every core cycle, not on the timebase, so a
  // 20 ns pulse spans several samples and is never missed.
  always_comb begin
    nxt_strobe_prev = watchdog_strobe_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      strobe_prev_ff <= 1'b0;
    end else begin
      strobe_prev_ff <= nxt_strobe_prev;
    end
  end

  assign strobe_fall = strobe_prev_ff & ~watchdog_strobe_in; // [R14]

  // Manual reset filter.
  manual_reset_debounce #(
    .DEBOUNCE_TICKS(DEBOUNCE_TICKS)
  ) u_debounce (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .tick_in(tick),
    .manual_reset_n_in(manual_reset_n_in),
    .pressed_out(mr_pressed)
  );

  // Conditions that hold reset for as long as they last.
  assign cause = ~supply_sync_ff | mr_pressed; // [R3]

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------

  // The unused code is read as floating, the middle setting.
  always_comb begin
    case (timeout_select_in)
      supervisor_pkg::TSEL_LOW: nxt_wd_limit = WD_LOW_TICKS; // [R10]
      supervisor_pkg::TSEL_FLOAT: nxt_wd_limit = WD_FLOAT_TICKS; // [R10]
      supervisor_pkg::TSEL_HIGH: nxt_wd_limit = WD_HIGH_TICKS; // [R10]
      default: nxt_wd_limit = WD_FLOAT_TICKS;
    endcase
    if (threshold_select_in) begin
      nxt_threshold = supervisor_pkg::THR_10PCT; // [R6]
    end else begin
      nxt_threshold = supervisor_pkg::THR_5PCT; // [R6]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      wd_limit_ff <= WD_LOW_TICKS;
      threshold_ff <= supervisor_pkg::THR_5PCT;
    end else begin
      wd_limit_ff <= nxt_wd_limit;
      threshold_ff <= nxt_threshold;
    end
  end

  // ---------------------------------------------------------------
  // Reset sequencer and watchdog
  // ---------------------------------------------------------------

  // Hold waits for every cause to clear, pulse times the guaranteed
  // width, and run watches the strobe. A new cause during a pulse goes
  // back to hold, so the full width is counted again once it clears.
  always_comb begin
    nxt_state = state_ff;
    nxt_pulse_cnt = pulse_cnt_ff;
    nxt_wd_cnt = supervisor_pkg::CNT_ZERO;
    case (state_ff)
      supervisor_pkg::st_hold: begin
        nxt_pulse_cnt = supervisor_pkg::CNT_ZERO;
        if (!cause) begin
          nxt_state = supervisor_pkg::st_pulse; // [R1] [R8]
        end
      end
      supervisor_pkg::st_pulse: begin
        if (cause) begin
          nxt_state = supervisor_pkg::st_hold; // [R4]
        end else if (tick) begin
          if (pulse_cnt_ff == RESET_TICKS - supervisor_pkg::CNT_ONE) begin
            nxt_state = supervisor_pkg::st_run; // [R5]
          end else begin
            nxt_pulse_cnt = pulse_cnt_ff + supervisor_pkg::CNT_ONE; // [R16]
          end
        end
      end
      supervisor_pkg::st_run: begin
        // The watchdog counts only here, with reset inactive.
        nxt_wd_cnt = wd_cnt_ff; // [R11]
        nxt_pulse_cnt = supervisor_pkg::CNT_ZERO;
        if (cause) begin
          nxt_state = supervisor_pkg::st_hold; // [R4]
          nxt_wd_cnt = supervisor_pkg::CNT_ZERO;
        end else if (strobe_fall) begin
          // A strobe on the last tick still counts as in time.
          nxt_wd_cnt = supervisor_pkg::CNT_ZERO; // [R13]
        end else if (tick) begin
          if (wd_cnt_ff >= wd_limit_ff - supervisor_pkg::CNT_ONE) begin
            nxt_state = supervisor_pkg::st_pulse; // [R12]
            nxt_wd_cnt = supervisor_pkg::CNT_ZERO;
          end else begin
            nxt_wd_cnt = wd_cnt_ff + supervisor_pkg::CNT_ONE; // [R16]
          end
        end
      end
      default: begin
        nxt_state = supervisor_pkg::st_hold;
        nxt_pulse_cnt = supervisor_pkg::CNT_ZERO;
      end
    endcase
    // Reset is active in every state but run.
    nxt_reset = (nxt_state != supervisor_pkg::st_run); // [R3]
  end

  // Leaving reset starts in hold, which is the power-up sequence.
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_ff <= supervisor_pkg::st_hold; // [R1]
      pulse_cnt_ff <= supervisor_pkg::CNT_ZERO;
      wd_cnt_ff <= supervisor_pkg::CNT_ZERO;
      reset_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      pulse_cnt_ff <= nxt_pulse_cnt;
      wd_cnt_ff <= nxt_wd_cnt;
      reset_ff <= nxt_reset;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Both pins come from one flop, so they can never disagree. The
  // open-drain pin only ever pulls low; the board pull-up makes high.
  assign reset_out = reset_ff; // [R2]
  assign reset_n_out = 1'b0; // [R2]
  assign reset_n_oe_out = reset_ff; // [R2]
  assign threshold_level_out = threshold_ff; // [R6]

endmodule // supply_supervisor_watchdog

`default_nettype wire

// *** testbench/supervisor_props.sv ***
// Purpose: Port assertions for the supply supervisor watchdog.
// Assumes: Bound into supply_supervisor_watchdog; one clock domain.
// Notes:   Long bounds use cycle counters, not repetitions.
`timescale 1ns/10ps
`default_nettype none
module supervisor_props #(
  parameter int RESET_TICKS = 32'h14,
  parameter int WD_LOW_TICKS = 32'ha,
  parameter int WD_FLOAT_TICKS = 32'h28,
  parameter int WD_HIGH_TICKS = 32'h50,
  parameter int DEBOUNCE_TICKS = 32'h5
) (
  // Clock, reset and monitored inputs.
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic supply_good_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_strobe_in,
  input wire logic [1:0] timeout_select_in,
  input wire logic threshold_select_in,
  // Outputs under watch.
  input wire logic threshold_level_out,
  input wire logic reset_out,
  input wire logic reset_n_out,
  input wire logic reset_n_oe_out
);
  // ----------------------------------------------------------------
  // Helper counters and checks
  // ----------------------------------------------------------------
  localparam int T = supervisor_pkg::TICK_CYCLES;
  logic [31:0] hi_cnt, wd_cnt, mr_cnt, lim;
  logic strobe_q;
  // Limit follows the pin; code 3 reads as the middle value.
  always_comb begin
    case (timeout_select_in)
      2'h0: lim = WD_LOW_TICKS;
      2'h2: lim = WD_HIGH_TICKS;
      default: lim = WD_FLOAT_TICKS;
    endcase
  end
  // Run lengths of reset high, watchdog idle and button low.
  always_ff @(posedge ref_clk_in) begin
    strobe_q <= watchdog_strobe_in;
    hi_cnt <= (!nrst_in || !reset_out) ? 32'h0 : hi_cnt + 32'h1;
    wd_cnt <= (!nrst_in || reset_out || (strobe_q && !watchdog_strobe_in))
      ? 32'h0 : wd_cnt + 32'h1;
    mr_cnt <= (!nrst_in || manual_reset_n_in) ? 32'h0 : mr_cnt + 32'h1;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_OD_ZERO: assert property (reset_n_out == 1'b0)
    else $error("open drain data not low");
  AST_OE_INV: assert property (reset_n_oe_out == reset_out)
    else $error("low reset not inverse of high reset");
  AST_SUPPLY_FAST: assert property ((!supply_good_in)[*6] |->
    reset_out)
    else $error("no reset on low supply");
  AST_HOLD_LOW: assert property (reset_out && !supply_good_in |=>
    reset_out)
    else $error("reset dropped while supply low");
  AST_THR: assert property ($past(nrst_in) |->
    threshold_level_out == $past(threshold_select_in))
    else $error("threshold level does not follow select");
  AST_PULSE_MIN: assert property ($fell(reset_out) |->
    $past(hi_cnt) >= (RESET_TICKS - 1) * T)
    else $error("reset pulse too short");
  AST_WD_LATE: assert property (wd_cnt <= (lim + 1) * T + 8)
    else $error("watchdog expiry missed");
  AST_WD_EARLY: assert property ($rose(reset_out) &&
    supply_good_in && manual_reset_n_in |-> $past(wd_cnt) >= (lim - 1) * T)
    else $error("reset without cause");
  AST_MR_SEEN: assert property (mr_cnt > (DEBOUNCE_TICKS + 1) * T + 4
    |-> reset_out)
    else $error("held button not recognised");
  // Main scenarios reached.
  cover property ($rose(reset_out) && supply_good_in && manual_reset_n_in);
  cover property (strobe_q && !watchdog_strobe_in && !reset_out);
  cover property ($fell(reset_out));
endmodule // supervisor_props

bind supply_supervisor_watchdog supervisor_props #(
  .RESET_TICKS(RESET_TICKS), .WD_LOW_TICKS(WD_LOW_TICKS),
  .WD_FLOAT_TICKS(WD_FLOAT_TICKS), .WD_HIGH_TICKS(WD_HIGH_TICKS),
  .DEBOUNCE_TICKS(DEBOUNCE_TICKS)
) props_i (.ref_clk_in, .nrst_in, .supply_good_in, .manual_reset_n_in,
  .watchdog_strobe_in, .timeout_select_in, .threshold_select_in,
  .threshold_level_out, .reset_out, .reset_n_out, .reset_n_oe_out);
`default_nettype wire

// *** testbench/host_strobe_model.sv ***
// Purpose: Host processor model that kicks the watchdog strobe.
// Assumes: Clocked by the supervisor clock.
// Notes:   Disabling it stands for a hung host; strobe then idles high.
`timescale 1ns/10ps
`default_nettype none
module host_strobe_model #(
  parameter int PERIOD = 32'h64
) (
  // Clock and enable.
  input wire logic ref_clk_in,
  input wire logic en_in,
  // Strobe toward the supervisor.
  output logic strobe_out
);
  // ----------------------------------------------------------------
  // Periodic kick
  // ----------------------------------------------------------------
  logic [31:0] cnt_ff;
  // Low for five cycles, the narrowest legal pulse, once a period.
  always_ff @(posedge ref_clk_in) begin
    cnt_ff <= (!en_in || cnt_ff >= PERIOD - 1) ? 32'h0 :
      cnt_ff + 32'h1;
    strobe_out <= !(en_in && cnt_ff < 32'h5);
  end
endmodule // host_strobe_model
`default_nettype wire

// *** testbench/supply_supervisor_watchdog_tb_top.sv ***
// Purpose: Self-checking bench for the supply supervisor watchdog.
// Assumes: Shortened tick counts; 1 us tick of 250 clocks.
// Notes:   Inputs change on rising edges, outputs read on falling ones.
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_watchdog_tb_top;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam int T = supervisor_pkg::TICK_CYCLES;
  // Short pulse keeps the whole run, code 3 included, well inside budget.
  localparam int RT = 6;
  localparam int DT = 4;
  logic ref_clk_in, nrst_in, supply_good_in, manual_reset_n_in;
  logic watchdog_strobe_in, threshold_select_in, host_en;
  logic [1:0] timeout_select_in;
  logic threshold_level_out, reset_out, reset_n_out, reset_n_oe_out;
  wire logic rst_wire = reset_n_oe_out ? reset_n_out : 1'b1;
  int num_errors, cmp_count;
  supply_supervisor_watchdog #(
    .RESET_TICKS(22'(RT)), .WD_LOW_TICKS(22'h8), .WD_FLOAT_TICKS(22'h10),
    .WD_HIGH_TICKS(22'h20), .DEBOUNCE_TICKS(22'(DT))
  ) uut (.ref_clk_in, .nrst_in, .supply_good_in, .manual_reset_n_in,
    .watchdog_strobe_in, .timeout_select_in, .threshold_select_in,
    .threshold_level_out, .reset_out, .reset_n_out, .reset_n_oe_out);
  host_strobe_model #(.PERIOD(32'h64)) host (.ref_clk_in, .en_in(host_en),
    .strobe_out(watchdog_strobe_in));
  // Free-running clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic check_bit(input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic check_range(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h..%h got=%h", $time, lo, hi, n);
    end
  endtask
  // Bounded wait for a reset level; a stuck output overruns the range.
  task automatic wait_rst(input logic v, output int n);
    n = 0;
    while (reset_out !== v && n < 60000) begin
      @(negedge ref_clk_in);
      n++;
    end
  endtask
  task automatic t_powerup;
    int n;
    wait_rst(1'b0, n);
    check_range(n, (RT - 1) * T, (RT + 2) * T);
  endtask
  task automatic t_threshold;
    @(posedge ref_clk_in) threshold_select_in <= 1'b1;
    repeat (2) @(negedge ref_clk_in);
    check_bit(1'b1, threshold_level_out);
    @(posedge ref_clk_in) threshold_select_in <= 1'b0;
    repeat (2) @(negedge ref_clk_in);
    check_bit(1'b0, threshold_level_out);
  endtask
  task automatic t_supply;
    int n;
    @(posedge ref_clk_in) supply_good_in <= 1'b0;
    repeat (6) @(negedge ref_clk_in);
    check_bit(1'b1, reset_out);
    check_bit(1'b0, rst_wire);
    repeat (T) @(negedge ref_clk_in);
    check_bit(1'b1, reset_out);
    @(posedge ref_clk_in) supply_good_in <= 1'b1;
    wait_rst(1'b0, n);
    check_range(n, (RT - 1) * T, (RT + 2) * T);
    check_bit(1'b1, rst_wire);
  endtask
  // A short press is filtered; a long one resets and holds after release.
  task automatic t_manual;
    int n;
    @(posedge ref_clk_in) manual_reset_n_in <= 1'b0;
    repeat ((DT - 2) * T) @(negedge ref_clk_in);
    @(posedge ref_clk_in) manual_reset_n_in <= 1'b1;
    repeat ((DT + 2) * T) @(negedge ref_clk_in);
    check_bit(1'b0, reset_out);
    @(posedge ref_clk_in) manual_reset_n_in <= 1'b0;
    repeat ((DT + 2) * T) @(negedge ref_clk_in);
    check_bit(1'b1, reset_out);
    @(posedge ref_clk_in) manual_reset_n_in <= 1'b1;
    wait_rst(1'b0, n);
    check_range(n, (RT - 1) * T, (DT + RT + 2) * T);
  endtask
  // Kicks keep it quiet; silence expires both from a kick and a release.
  task automatic t_watchdog(input logic [1:0] sel, input int lim);
    int n;
    @(posedge ref_clk_in) timeout_select_in <= sel;
    repeat ((lim + 4) * T) @(negedge ref_clk_in);
    check_bit(1'b0, reset_out);
    @(posedge ref_clk_in) host_en <= 1'b0;
    wait_rst(1'b1, n);
    check_range(n, (lim - 1) * T - 100, (lim + 1) * T + 8);
    wait_rst(1'b0, n);
    check_range(n, (RT - 1) * T, (RT + 1) * T + 8);
    wait_rst(1'b1, n);
    check_range(n, (lim - 1) * T, (lim + 1) * T + 8);
    wait_rst(1'b0, n);
    @(posedge ref_clk_in) host_en <= 1'b1;
  endtask
  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    nrst_in = 1'b0;
    supply_good_in = 1'b1;
    manual_reset_n_in = 1'b1;
    timeout_select_in = 2'h0;
    threshold_select_in = 1'b0;
    host_en = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    host_en <= 1'b1;
    t_powerup();
    t_threshold();
    t_supply();
    t_manual();
    t_watchdog(2'h0, 8);
    t_watchdog(2'h1, 16);
    t_watchdog(2'h2, 32);
    // The unused select code must behave as the middle setting.
    t_watchdog(2'h3, 16);
    final_report();
  end
  // Hang guard sized above the expected run of about 80000 cycles.
  initial begin
    repeat (95000) @(posedge ref_clk_in);
    num_errors++;
    final_report();
  end
endmodule // supply_supervisor_watchdog_tb_top
`default_nettype wire
